// ===== pkg/fes_defs.vh
`ifndef FES_DEFS_VH
`define FES_DEFS_VH
// ------------------------------------------------------------
// Opcodes
// ------------------------------------------------------------
`define FES_OP_ERASE_32K 8'h52
`define FES_OP_ERASE_64K 8'hd8
`define FES_OP_FULL_ERASE_A 8'hc7
`define FES_OP_FULL_ERASE_B 8'h60
`define FES_OP_SET_LATCH 8'h06
`define FES_OP_CLEAR_LATCH 8'h04
`define FES_OP_STATUS_READ 8'h05
`define FES_OP_STATUS_WRITE 8'h01
`define FES_OP_FUNC_READ 8'h48
`define FES_OP_FUNC_WRITE 8'h42
`define FES_OP_ENTER_4W 8'h35
`define FES_OP_EXIT_4W 8'hf5
`define FES_OP_SUSPEND_A 8'h75
`define FES_OP_SUSPEND_B 8'hb0
`define FES_OP_RESUME_A 8'h7a
`define FES_OP_RESUME_B 8'h30
// ------------------------------------------------------------
// Status register fields
// ------------------------------------------------------------
`define FES_SR_WIP 0
`define FES_SR_WEL 1
`define FES_SR_BP_LO 2
`define FES_SR_BP_HI 5
`define FES_SR_QE 6
`define FES_SR_STATUS_WRITE_DISABLE 7
`define FES_SR_NV_MASK 8'hfc
// ------------------------------------------------------------
// Function register fields
// ------------------------------------------------------------
`define FES_FR_RST_DIS 0
`define FES_FR_PROGRAM_SUSPENDED_FLAG 2
`define FES_FR_ERASE_SUSPENDED_FLAG 3
`define FES_FR_IRL_LO 4
`define FES_FR_OTP_MASK 8'hf1
// ------------------------------------------------------------
// Framing and timing
// ------------------------------------------------------------
`define FES_BITS_OPCODE 6'h08
`define FES_BITS_WITH_ADDR 6'h20
`define FES_BITS_WITH_DATA 6'h10
`define FES_NIB_OPCODE 6'h02
`define FES_NIB_WITH_ADDR 6'h08
`define FES_NIB_WITH_DATA 6'h04
`define FES_ADDR_W 22
`define FES_ADDR_32K_LO 15
`define FES_ADDR_64K_LO 16
`define FES_CLK_MHZ 25
`define FES_T_SUS_US 100
// Suspend ready count, sized to the 16-bit counter it loads
`define FES_SUS_CYC 16'h09c4
`define FES_ERASE_CYC 16'h0400
`define FES_FULL_ERASE_CYC 16'h2000
`define FES_PROG_CYC 16'h0100
`define FES_KIND_NONE 2'h0
`define FES_KIND_BLOCK 2'h1
`define FES_KIND_FULL 2'h2
`define FES_KIND_PROG 2'h3
`endif

// ===== rtl/fes_sync.v
`timescale 1ns/1ps
// ------------------------------------------------------------
// Two-flop level synchroniser, one per bit
// ------------------------------------------------------------
module fes_sync #(
  parameter W = 6
) (
  // Clock and reset
  input wire clk,
  input wire rst_n,
  // Data
  input wire [W-1:0] d,
  output wire [W-1:0] q
);
  genvar i;
  generate
    for (i = 0; i < W; i = i + 1) begin : g_bit
      reg s1_q;
      reg s2_q;
      always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
          s1_q <= 1'b0;
          s2_q <= 1'b0;
        end else begin
          s1_q <= d[i];
          s2_q <= s1_q;
        end
      end
      assign q[i] = s2_q;
    end
  endgenerate
endmodule // fes_sync

// ===== rtl/fes_ctl.v
`timescale 1ns/1ps
`include "fes_defs.vh"
module fes_ctl (
  // Clock and reset
  input wire clk,
  input wire rst_n,
  // Serial link pins
  input wire cs_n,
  input wire sck,
  input wire [3:0] io_in,
  output reg [3:0] io_out,
  output reg [3:0] io_oe,
  // Program engine handshake from elsewhere in the device
  input wire prog_start,
  // Array erase requests
  output reg erase_req,
  output reg [1:0] erase_kind,
  output reg [21:0] erase_base,
  output reg [21:0] erase_mask,
  // Status
  output reg [7:0] status_reg,
  output reg [7:0] func_reg,
  output reg four_wire_command_mode,
  output reg erase_fail_flag,
  output reg protection_error_flag,
  output reg program_suspended_flag,
  output reg erase_suspended_flag
);
  // ------------------------------------------------------------
  // Pin synchronisers
  // ------------------------------------------------------------
  wire [5:0] pin_s;
  fes_sync #(.W(6)) u_sync (
    .clk(clk),
    .rst_n(rst_n),
    .d({~cs_n, sck, io_in}),
    .q(pin_s)
  );
  // Inverted so the flops' reset value reads as deselected: no false edge
  wire cs_s = ~pin_s[5];
  wire sck_s = pin_s[4];
  wire [3:0] io_s = pin_s[3:0];
  reg sck_d_q;
  reg cs_d_q;
  wire sck_rise = sck_s & ~sck_d_q;
  wire sck_fall = ~sck_s & sck_d_q;
  wire cs_rise = cs_s & ~cs_d_q;
  // ------------------------------------------------------------
  // Shift-in and frame state
  // ------------------------------------------------------------
  reg [31:0] shift_q;
  reg [5:0] cnt_q;
  reg [7:0] op_q;
  reg [7:0] tx_q;
  reg tx_on_q;
  reg [7:0] status_q;
  reg [7:0] func_q;
  reg wel_q;
  reg four_q;
  reg [1:0] busy_kind_q;
  reg [15:0] busy_cnt_q;
  reg [15:0] sus_cnt_q;
  reg [15:0] sus_left_q;
  reg erase_suspended_flag_q;
  reg program_suspended_flag_q;
  reg [1:0] sus_kind_q;
  wire [5:0] op_len = four_q ? `FES_NIB_OPCODE : `FES_BITS_OPCODE;
  wire [5:0] addr_len = four_q ? `FES_NIB_WITH_ADDR : `FES_BITS_WITH_ADDR;
  wire [5:0] data_len = four_q ? `FES_NIB_WITH_DATA : `FES_BITS_WITH_DATA;
  wire [31:0] shift_nx = four_q ? {shift_q[27:0], io_s} : {shift_q[30:0], io_s[0]};
  wire write_in_progress = (busy_kind_q != `FES_KIND_NONE) | (sus_cnt_q != 16'h0000);
  wire sus_busy = sus_cnt_q != 16'h0000;
  wire [3:0] bp = status_q[`FES_SR_BP_HI:`FES_SR_BP_LO];
  // ------------------------------------------------------------
  // Command decode at deselect
  // ------------------------------------------------------------
  wire at_op = cnt_q == op_len;
  wire at_addr = cnt_q == addr_len;
  wire at_data = cnt_q == data_len;
  wire is_blk = (op_q == `FES_OP_ERASE_32K) | (op_q == `FES_OP_ERASE_64K);
  wire is_full = (op_q == `FES_OP_FULL_ERASE_A) | (op_q == `FES_OP_FULL_ERASE_B);
  wire is_sus = (op_q == `FES_OP_SUSPEND_A) | (op_q == `FES_OP_SUSPEND_B);
  wire is_rsm = (op_q == `FES_OP_RESUME_A) | (op_q == `FES_OP_RESUME_B);
  wire [7:0] cur_op = four_q ? shift_nx[7:0] : shift_nx[7:0];
  wire [21:0] addr_in = shift_q[`FES_ADDR_W-1:0];
  // Any suspend blocks status writes and new erases
  wire any_sus = erase_suspended_flag_q | program_suspended_flag_q;
  wire idle = (busy_kind_q == `FES_KIND_NONE) & ~sus_busy;
  wire do_blk = cs_rise & is_blk & at_addr & wel_q & idle & ~any_sus;
  wire do_full = cs_rise & is_full & at_op & wel_q & idle & ~any_sus;
  wire do_status_write_cmd = cs_rise & (op_q == `FES_OP_STATUS_WRITE) & at_data & wel_q & idle
    & ~any_sus;
  wire do_function_write_cmd = cs_rise & (op_q == `FES_OP_FUNC_WRITE) & at_data & wel_q & idle;
  wire do_set_latch_cmd = cs_rise & (op_q == `FES_OP_SET_LATCH) & at_op & ~sus_busy;
  wire do_clear_latch_cmd = cs_rise & (op_q == `FES_OP_CLEAR_LATCH) & at_op & ~sus_busy;
  wire do_sus = cs_rise & is_sus & at_op & ~sus_busy & ~any_sus
    & ((busy_kind_q == `FES_KIND_BLOCK) | (busy_kind_q == `FES_KIND_PROG));
  wire do_rsm = cs_rise & is_rsm & at_op & idle & any_sus;
  wire do_en4 = cs_rise & (op_q == `FES_OP_ENTER_4W) & at_op & ~four_q & idle;
  wire do_ex4 = cs_rise & (op_q == `FES_OP_EXIT_4W) & at_op & four_q & idle;
  wire prog_ok = prog_start & wel_q & idle & ~program_suspended_flag_q;
  // ------------------------------------------------------------
  // Main sequential logic
  // ------------------------------------------------------------
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      sck_d_q <= 1'b0;
      cs_d_q <= 1'b1;
      shift_q <= 32'h00000000;
      cnt_q <= 6'h00;
      op_q <= 8'h00;
      tx_q <= 8'h00;
      tx_on_q <= 1'b0;
      status_q <= 8'h00;
      func_q <= 8'h00;
      wel_q <= 1'b0;
      four_q <= 1'b0;
      busy_kind_q <= `FES_KIND_NONE;
      busy_cnt_q <= 16'h0000;
      sus_cnt_q <= 16'h0000;
      sus_left_q <= 16'h0000;
      erase_suspended_flag_q <= 1'b0;
      program_suspended_flag_q <= 1'b0;
      sus_kind_q <= `FES_KIND_NONE;
      erase_req <= 1'b0;
      erase_kind <= `FES_KIND_NONE;
      erase_base <= 22'h000000;
      erase_mask <= 22'h000000;
      erase_fail_flag <= 1'b0;
      protection_error_flag <= 1'b0;
      io_out <= 4'h0;
      io_oe <= 4'h0;
    end else begin
      sck_d_q <= sck_s;
      cs_d_q <= cs_s;
      erase_req <= 1'b0;
      // Frame shifting; count saturates so overlong frames never decode
      if (cs_s) begin
        cnt_q <= 6'h00;
        tx_on_q <= 1'b0;
        io_oe <= 4'h0;
      end else if (sck_rise) begin
        shift_q <= shift_nx;
        if (cnt_q != 6'h3f) begin
          cnt_q <= cnt_q + 6'h01;
        end
        if (cnt_q + 6'h01 == op_len) begin
          op_q <= cur_op;
          // Status read stays usable while busy
          if (cur_op == `FES_OP_STATUS_READ) begin
            tx_q <= {status_q[7:2], wel_q, write_in_progress};
            tx_on_q <= 1'b1;
          end else if (cur_op == `FES_OP_FUNC_READ) begin
            tx_q <= {func_q[7:4], erase_suspended_flag_q, program_suspended_flag_q, func_q[1:0]};
            tx_on_q <= 1'b1;
          end
        end
      end else if (sck_fall & tx_on_q) begin
        if (four_q) begin
          io_out <= tx_q[7:4];
          io_oe <= 4'hf;
          tx_q <= {tx_q[3:0], tx_q[7:4]};
        end else begin
          io_out <= {2'b00, tx_q[7], 1'b0};
          io_oe <= 4'h2;
          tx_q <= {tx_q[6:0], tx_q[7]};
        end
      end
      // Latch handling
      if (do_set_latch_cmd) begin
        wel_q <= 1'b1;
      end
      if (do_clear_latch_cmd) begin
        wel_q <= 1'b0;
      end
      if (do_status_write_cmd) begin
        status_q <= shift_q[7:0] & `FES_SR_NV_MASK;
        wel_q <= 1'b0;
      end
      if (do_function_write_cmd) begin
        func_q <= (func_q & `FES_FR_OTP_MASK) | (shift_q[7:0] & `FES_FR_OTP_MASK);
        wel_q <= 1'b0;
      end
      if (do_en4) begin
        four_q <= 1'b1;
      end
      if (do_ex4) begin
        four_q <= 1'b0;
      end
      // Erase launch
      if (do_blk) begin
        busy_kind_q <= `FES_KIND_BLOCK;
        busy_cnt_q <= `FES_ERASE_CYC;
        erase_req <= 1'b1;
        erase_kind <= `FES_KIND_BLOCK;
        erase_fail_flag <= 1'b0;
        if (op_q == `FES_OP_ERASE_32K) begin
          erase_mask <= (22'h000001 << `FES_ADDR_32K_LO) - 22'h000001;
          erase_base <= addr_in & ~((22'h000001 << `FES_ADDR_32K_LO) - 22'h000001);
        end else begin
          erase_mask <= (22'h000001 << `FES_ADDR_64K_LO) - 22'h000001;
          erase_base <= addr_in & ~((22'h000001 << `FES_ADDR_64K_LO) - 22'h000001);
        end
      end
      if (do_full) begin
        if (bp != 4'h0) begin
          erase_fail_flag <= 1'b1;
          protection_error_flag <= 1'b1;
        end else begin
          busy_kind_q <= `FES_KIND_FULL;
          busy_cnt_q <= `FES_FULL_ERASE_CYC;
          erase_req <= 1'b1;
          erase_kind <= `FES_KIND_FULL;
          erase_base <= 22'h000000;
          erase_mask <= 22'h3fffff;
          erase_fail_flag <= 1'b0;
          protection_error_flag <= 1'b0;
        end
      end
      if (prog_ok) begin
        busy_kind_q <= `FES_KIND_PROG;
        busy_cnt_q <= `FES_PROG_CYC;
      end
      // Suspend freezes the running count; the engine resumes where it stopped
      if (do_sus) begin
        sus_kind_q <= busy_kind_q;
        busy_kind_q <= `FES_KIND_NONE;
        sus_cnt_q <= `FES_SUS_CYC;
        sus_left_q <= busy_cnt_q;
        if (busy_kind_q == `FES_KIND_BLOCK) begin
          erase_suspended_flag_q <= 1'b1;
        end else begin
          program_suspended_flag_q <= 1'b1;
        end
        wel_q <= 1'b0;
      end else if (do_rsm) begin
        busy_kind_q <= sus_kind_q;
        busy_cnt_q <= sus_left_q;
        erase_suspended_flag_q <= 1'b0;
        program_suspended_flag_q <= 1'b0;
      end else if (sus_busy) begin
        sus_cnt_q <= sus_cnt_q - 16'h0001;
      end else if ((busy_kind_q != `FES_KIND_NONE) & ~do_blk & ~do_full & ~prog_ok) begin
        if (busy_cnt_q == 16'h0001) begin
          busy_kind_q <= `FES_KIND_NONE;
          // A set command in the same cycle wins over the completion clear
          if (!do_set_latch_cmd) begin
            wel_q <= 1'b0;
          end
        end
        busy_cnt_q <= busy_cnt_q - 16'h0001;
      end
    end
  end
  // ------------------------------------------------------------
  // Registered status outputs
  // ------------------------------------------------------------
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      status_reg <= 8'h00;
      func_reg <= 8'h00;
      four_wire_command_mode <= 1'b0;
      program_suspended_flag <= 1'b0;
      erase_suspended_flag <= 1'b0;
    end else begin
      status_reg <= {status_q[7:2], wel_q, write_in_progress};
      func_reg <= {func_q[7:4], erase_suspended_flag_q, program_suspended_flag_q, func_q[1:0]};
      four_wire_command_mode <= four_q;
      program_suspended_flag <= program_suspended_flag_q;
      erase_suspended_flag <= erase_suspended_flag_q;
    end
  end
endmodule // fes_ctl

// ===== sim/fes_ctl_asserts.sv
`timescale 1ns/1ps
// ----------
// Port checks
// ----------
module fes_ctl_asserts (
  // Clock and reset
  input wire clk,
  input wire rst_n,
  // Observed outputs
  input wire erase_req,
  input wire [1:0] erase_kind,
  input wire [21:0] erase_base,
  input wire [21:0] erase_mask,
  input wire [7:0] status_reg,
  input wire [7:0] func_reg,
  input wire erase_suspended_flag
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  a_req_one_cycle: assert property (erase_req |=> !erase_req)
    else $error("erase request wider than one cycle");
  a_req_needs_latch: assert property (erase_req |-> status_reg[1])
    else $error("erase launched with latch clear");
  a_req_sets_busy: assert property (erase_req |-> ##[0:2] status_reg[0])
    else $error("busy bit not raised by erase");
  a_full_unprotected: assert property (erase_req && erase_kind == 2'h2
    |-> status_reg[5:2] == 4'h0)
    else $error("full erase launched with protect bits set");
  a_block_aligned: assert property (erase_req && erase_kind == 2'h1
    |-> (erase_base & erase_mask) == 22'h0
    && (erase_mask == 22'h007fff || erase_mask == 22'h00ffff))
    else $error("block region not aligned to its size");
  a_susp_drops_latch: assert property ($rose(erase_suspended_flag)
    |-> ##[0:2] !status_reg[1])
    else $error("latch kept after suspend");
  a_susp_func_bit: assert property ($rose(erase_suspended_flag) |-> ##[0:1] func_reg[3])
    else $error("function register misses erase suspend");
  a_otp_sticky: assert property ((($past(func_reg) & 8'hf1) & ~func_reg) == 8'h00)
    else $error("one-time bit returned to zero");
endmodule // fes_ctl_asserts
bind fes_ctl fes_ctl_asserts fes_ctl_asserts_inst (.clk(clk), .rst_n(rst_n),
  .erase_req(erase_req), .erase_kind(erase_kind), .erase_base(erase_base),
  .erase_mask(erase_mask), .status_reg(status_reg), .func_reg(func_reg),
  .erase_suspended_flag(erase_suspended_flag));

// ===== sim/fes_host.sv
`timescale 1ns/1ps
// ----------
// Host controller model, sck idles low
// ----------
module fes_host (
  // Link pins
  output reg cs_n,
  output reg sck,
  output reg [3:0] io,
  // Device answer
  input wire [3:0] io_out
);
  initial begin
    cs_n = 1'b1;
    sck = 1'b0;
    io = 4'ha;
  end
  // Whole units only, MSB first; quad sends n/4 nibbles
  task xfer(input [31:0] v, input integer n, input quad, input integer rn, output [7:0] rd);
    integer i;
    begin
      rd = 8'h00;
      cs_n = 1'b0;
      for (i = (quad ? n / 4 : n) - 1; i >= 0; i = i - 1) begin
        io = quad ? v[i * 4 +: 4] : {io[3:1], v[i]};
        #160 sck = 1'b1;
        #160 sck = 1'b0;
      end
      for (i = 0; i < rn; i = i + 1) begin
        #160 sck = 1'b1;
        #160 rd = {rd[6:0], io_out[1]};
        sck = 1'b0;
      end
      #160 cs_n = 1'b1;
      io = ~io; // Released lines must not keep the last value
      #400;
    end
  endtask
endmodule // fes_host

// ===== sim/fes_ctl_tb.sv
`timescale 1ns/1ps
`include "fes_defs.vh"
module fes_ctl_tb;
  // ----------
  // Signals
  // ----------
  logic clk, rst_n, prog_start, cs_n, sck, quad, erase_req, four_wire_command_mode;
  logic erase_fail_flag, protection_error_flag, program_suspended_flag, erase_suspended_flag;
  logic [3:0] host_io, io_out, io_oe;
  wire [3:0] io_in = (io_oe & io_out) | (~io_oe & host_io);
  logic [1:0] erase_kind;
  logic [21:0] erase_base, erase_mask, a, m;
  logic [7:0] status_reg, func_reg, rd;
  logic [45:0] expq[$];
  logic [31:0] seed = 32'h00000056;
  int fails, n_compared, i;
  fes_ctl fes_ctl_inst (.clk(clk), .rst_n(rst_n), .cs_n(cs_n), .sck(sck), .io_in(io_in),
    .io_out(io_out), .io_oe(io_oe), .prog_start(prog_start), .erase_req(erase_req),
    .erase_kind(erase_kind), .erase_base(erase_base), .erase_mask(erase_mask),
    .status_reg(status_reg), .func_reg(func_reg),
    .four_wire_command_mode(four_wire_command_mode), .erase_fail_flag(erase_fail_flag),
    .protection_error_flag(protection_error_flag),
    .program_suspended_flag(program_suspended_flag),
    .erase_suspended_flag(erase_suspended_flag));
  fes_host fes_host_inst (.cs_n(cs_n), .sck(sck), .io(host_io), .io_out(io_out));
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  // ----------
  // Helpers
  // ----------
  function automatic logic [31:0] xs();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction
  task chk(input string nm, input logic [47:0] seen, input logic [47:0] exp);
    n_compared++;
    if (seen !== exp) begin
      fails++;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task op(input logic [31:0] v, input int n, input int rn = 0);
    @(posedge clk);
    #1;
    fes_host_inst.xfer(v, n, quad, rn, rd);
  endtask
  task wait_idle();
    for (int k = 0; k < 10000 && status_reg[0] !== 1'b0; k++) begin
      @(posedge clk);
      #1;
    end
  endtask
  task conclude();
    $display("compared %0d failed %0d", n_compared, fails);
    if (fails == 0 && n_compared > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  // ----------
  // Scoreboard of erase launches
  // ----------
  always @(negedge clk) begin
    if (erase_req === 1'b1) begin
      if (expq.size() == 0)
        chk("unexpected_erase", 1, 0);
      else begin
        chk("erase_kind", erase_kind, expq[0][45:44]);
        chk("erase_region", {erase_base, erase_mask}, expq[0][43:0]);
        void'(expq.pop_front());
      end
    end
  end
  initial begin
    #3000000;
    fails++;
    conclude();
  end
  // ----------
  // Main sequence
  // ----------
  initial begin
    rst_n = 1'b0;
    prog_start = 1'b0;
    quad = 1'b0;
    repeat (16) @(posedge clk);
    #1 rst_n = 1'b1;
    repeat (4) @(posedge clk);
    #1 chk("status_reset", status_reg, 8'h00);
    op({`FES_OP_ERASE_32K, 24'h000000}, 32);
    @(posedge clk) #1 prog_start = 1'b1;
    @(posedge clk) #1 prog_start = 1'b0;
    repeat (8) @(posedge clk);
    #1 chk("busy_without_latch", status_reg[0], 1'b0);
    op(`FES_OP_SET_LATCH, 8);
    chk("latch_set", status_reg[1], 1'b1);
    op(`FES_OP_CLEAR_LATCH, 8);
    chk("latch_clear", status_reg[1], 1'b0);
    op(`FES_OP_SET_LATCH, 8);
    op({`FES_OP_ERASE_64K, 24'h123456} >> 1, 31);
    chk("short_frame", status_reg[1:0], 2'h2);
    for (i = 0; i < 4; i++) begin
      if (i == 2) begin
        op(`FES_OP_ENTER_4W, 8);
        quad = 1'b1;
        chk("four_wire_on", four_wire_command_mode, 1'b1);
      end
      a = 22'(xs());
      m = i[0] ? 22'h00ffff : 22'h007fff;
      op(`FES_OP_SET_LATCH, 8);
      expq.push_back({2'h1, a & ~m, m});
      op({i[0] ? `FES_OP_ERASE_64K : `FES_OP_ERASE_32K, 2'h0, a}, 32);
      if (i[0]) begin
        op(i[1] ? `FES_OP_SUSPEND_B : `FES_OP_SUSPEND_A, 8);
        chk("suspended", {erase_suspended_flag, func_reg[3], status_reg[1]}, 3'h6);
        repeat (2600) @(posedge clk);
        op(`FES_OP_SET_LATCH, 8);
        op({`FES_OP_STATUS_WRITE, 8'h3c}, 16);
        chk("write_refused", status_reg[5:2], 4'h0);
        op(i[1] ? `FES_OP_RESUME_B : `FES_OP_RESUME_A, 8);
        chk("resumed", erase_suspended_flag, 1'b0);
      end else if (!quad) begin
        op(`FES_OP_STATUS_READ, 8, 8);
        chk("busy_read", rd[1:0], 2'h3);
      end
      wait_idle(); // Long gap before any later suspend
      chk("erase_done", status_reg[1:0], 2'h0);
    end
    op(`FES_OP_EXIT_4W, 8);
    quad = 1'b0;
    chk("four_wire_off", four_wire_command_mode, 1'b0);
    op(`FES_OP_SET_LATCH, 8);
    @(posedge clk) #1 prog_start = 1'b1;
    @(posedge clk) #1 prog_start = 1'b0;
    op(`FES_OP_SUSPEND_B, 8);
    chk("prog_susp", {program_suspended_flag, func_reg[2], status_reg[1]}, 3'h6);
    repeat (2600) @(posedge clk);
    op(`FES_OP_SET_LATCH, 8);
    op({`FES_OP_STATUS_WRITE, 8'h3c}, 16);
    chk("prog_write_refused", status_reg[5:1], 5'h01);
    op(`FES_OP_RESUME_A, 8);
    chk("prog_resumed", {program_suspended_flag, status_reg[0]}, 2'h1);
    wait_idle();
    chk("prog_done", status_reg[1:0], 2'h0);
    op(`FES_OP_SET_LATCH, 8);
    op({`FES_OP_STATUS_WRITE, 8'h3c}, 16);
    wait_idle();
    chk("status_written", status_reg, 8'h3c);
    op(`FES_OP_SET_LATCH, 8);
    op(`FES_OP_FULL_ERASE_A, 8);
    chk("protect_fail", {erase_fail_flag, protection_error_flag}, 2'h3);
    op(`FES_OP_SET_LATCH, 8);
    op({`FES_OP_STATUS_WRITE, 8'h00}, 16);
    wait_idle();
    op(`FES_OP_SET_LATCH, 8);
    op({`FES_OP_FULL_ERASE_B, 8'h00}, 16);
    chk("full_with_tail", status_reg[1:0], 2'h2);
    expq.push_back({2'h2, 22'h000000, 22'h3fffff});
    op(`FES_OP_FULL_ERASE_B, 8);
    op(`FES_OP_SUSPEND_A, 8);
    chk("full_not_suspended", {erase_suspended_flag, status_reg[0]}, 2'h1);
    wait_idle();
    chk("full_done", status_reg[1:0], 2'h0);
    for (i = 0; i < 2; i++) begin
      op(`FES_OP_SET_LATCH, 8);
      op({`FES_OP_FUNC_WRITE, i[0] ? 8'h00 : 8'hf1}, 16);
      wait_idle();
    end
    op(`FES_OP_FUNC_READ, 8, 8);
    chk("func_sticky", {rd, func_reg}, 16'hf1f1);
    chk("erase_pending", expq.size(), 0);
    conclude();
  end
endmodule // fes_ctl_tb
